// *** hw/spp_defines.svh ***
// register addresses, control word fields, port c line positions and reset values
// assumes: included by bare name wherever these constants are needed
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

`define SPP_ADDR_PORTA  2'h0
`define SPP_ADDR_PORTB  2'h1
`define SPP_ADDR_PORTC  2'h2
`define SPP_ADDR_CTRL   2'h3

// control word, bit 7 high: mode set
`define SPP_CW_MODESET  7
`define SPP_CW_AMODE_HI 6
`define SPP_CW_AMODE_LO 5
`define SPP_CW_A_IN     4
`define SPP_CW_CU_IN    3
`define SPP_CW_B_MODE   2
`define SPP_CW_B_IN     1
`define SPP_CW_CL_IN    0

// control word, bit 7 low: single bit set/reset of port c
`define SPP_BSR_SEL_HI  3
`define SPP_BSR_SEL_LO  1
`define SPP_BSR_VAL     0

// port c line positions used by handshaking
`define SPP_PC_IRQ_B    3'h0
`define SPP_PC_FULL_B   3'h1
`define SPP_PC_HS_B     3'h2
`define SPP_PC_IRQ_A    3'h3
`define SPP_PC_STRB_A   3'h4
`define SPP_PC_INFULL_A 3'h5
`define SPP_PC_ACC_A    3'h6
`define SPP_PC_OUTFUL_A 3'h7

`define SPP_RST_DATA    8'h00
`define SPP_RST_OEN     8'hff

`endif

// *** hw/spp_handshake.sv ***
// three-port parallel interface: mode control, port c handshaking and bit set/reset
// assumes: one clock, host reaches it over a plain strobed register port,
// pin inputs are synchronous; port c lines are resampled before edge use
//
// Contract
// - strobed output raises interrupt when accept, buffer-free line and mask high; write clears.
// - strobed output masks set by port c bit 6 (group A), bit 2 (group B).
// - ports A and B each independently strobed input or strobed output.
// - bidirectional mode only for group A, port A bus plus five port c lines.
// - bidirectional mode drives output-buffer-full line low after host writes port A.
// - bidirectional mode drives port A only while accept input is low.
// - bidirectional masks: output side by port c bit 6, input side by bit 4.
// - bidirectional strobe low captures port A, then input-latch-full goes high.
// - one interrupt serves both directions with the combined input/output condition.
// - strobed mode assigns port c lines to handshake roles per group and direction.
// - bidirectional mode uses port c bits 3 to 7; bits 0 to 2 serve group B.
// - spare port c input bits are returned on a normal port c read.
// - spare upper port c outputs change only by bit set/reset, except with group A basic, where a direct write also changes them.
// - spare lower port c outputs change by bit set/reset or direct write.
// - in strobed or bidirectional modes port c read returns handshake status.
// - in basic mode port c is a plain data port.
// - output-buffer-full sets at end of host write, clears on accept low.
// - input-latch-full sets while strobe low, clears at end of host read.
// - mode selection clears output registers and handshake flops.
// - mode selection and reset clear every interrupt mask.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "spp_defines.svh"

module spp_handshake (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStb,
   input  wire logic       rdStb,
   output logic      [7:0] rdData,
   input  wire logic [7:0] portAIn,
   output logic      [7:0] portAOut,
   output logic            portAOeN,
   input  wire logic [7:0] portBIn,
   output logic      [7:0] portBOut,
   output logic            portBOeN,
   input  wire logic [7:0] portCIn,
   output logic      [7:0] portCOut,
   output logic      [7:0] portCOeN
);

   function automatic logic irqTerm(input logic flagLine, input logic mask,
                                    input logic periphHigh, input logic hostBusy);
      irqTerm = flagLine & mask & periphHigh & ~hostBusy;
   endfunction

   function automatic logic [7:0] bitMask(input logic [2:0] pos);
      bitMask = 8'h01 << pos;
   endfunction

   spp_pkg::sppModeA_t modeA_q;
   spp_pkg::sppModeB_t modeB_q;
   logic       dirAIn_q, dirBIn_q, dirCuIn_q, dirClIn_q;
   logic [7:0] outALatch_q, outBLatch_q, inALatch_q, inBLatch_q, portCLatch_q;
   logic [7:0] pcMeta_q, pcSync_q;
   logic       wrAEnd_q, rdAEnd_q, wrBEnd_q, rdBEnd_q;
   logic       outFullA_q, inFullA_q, outFullB_q, inFullB_q;
   logic       irqA_q, irqB_q;
   logic       outSideIrqMask_q, inSideIrqMask_q, irqMaskB_q;
   logic [7:0] rdData_q, portAOut_q, portBOut_q, portCOut_q, portCOeN_q;
   logic       portAOeN_q, portBOeN_q;

   // host side decode
   wire logic selA     = (addr == `SPP_ADDR_PORTA);
   wire logic selB     = (addr == `SPP_ADDR_PORTB);
   wire logic selC     = (addr == `SPP_ADDR_PORTC);
   wire logic selCtl   = (addr == `SPP_ADDR_CTRL);
   wire logic wrA      = wrStb & selA;
   wire logic rdA      = rdStb & selA;
   wire logic wrB      = wrStb & selB;
   wire logic rdB      = rdStb & selB;
   wire logic wrC      = wrStb & selC;
   wire logic wrCtl    = wrStb & selCtl;
   wire logic modeSet  = wrCtl & wrData[`SPP_CW_MODESET];
   wire logic bitOp    = wrCtl & ~wrData[`SPP_CW_MODESET];
   wire logic [2:0] bitSel = wrData[`SPP_BSR_SEL_HI:`SPP_BSR_SEL_LO];
   wire logic bitVal   = wrData[`SPP_BSR_VAL];

   // mode decode
   wire logic aBasic   = (modeA_q == spp_pkg::SPP_A_BASIC);
   wire logic aStrb    = (modeA_q == spp_pkg::SPP_A_STROBED);
   wire logic aBidir   = (modeA_q == spp_pkg::SPP_A_BIDIR);
   wire logic bStrb    = (modeB_q == spp_pkg::SPP_B_STROBED);
   wire logic aOutSide = aBidir | (aStrb & ~dirAIn_q);
   wire logic aInSide  = aBidir | (aStrb & dirAIn_q);
   wire logic bOutSide = bStrb & ~dirBIn_q;
   wire logic bInSide  = bStrb & dirBIn_q;

   // peripheral lines after resynchronisation
   wire logic strbAHigh = pcSync_q[`SPP_PC_STRB_A];
   wire logic accAHigh  = pcSync_q[`SPP_PC_ACC_A];
   wire logic hsBHigh   = pcSync_q[`SPP_PC_HS_B];

   // a host access counts as busy during its strobe and the cycle after it,
   // so an interrupt cannot blip while the full flag is still settling
   wire logic wrABusy  = wrA | wrAEnd_q;
   wire logic rdABusy  = rdA | rdAEnd_q;
   wire logic wrBBusy  = wrB | wrBEnd_q;
   wire logic rdBBusy  = rdB | rdBEnd_q;

   wire spp_pkg::sppModeA_t modeA_d =
      wrData[`SPP_CW_AMODE_HI] ? spp_pkg::SPP_A_BIDIR :
      wrData[`SPP_CW_AMODE_LO] ? spp_pkg::SPP_A_STROBED : spp_pkg::SPP_A_BASIC;
   wire spp_pkg::sppModeB_t modeB_d =
      wrData[`SPP_CW_B_MODE] ? spp_pkg::SPP_B_STROBED : spp_pkg::SPP_B_BASIC;

   // full flags: mode set clears first; otherwise the setting event wins over a clear in the same cycle
   wire logic outFullA_d = modeSet ? 1'b0 :
                           (wrAEnd_q & aOutSide) ? 1'b1 :
                           ~accAHigh ? 1'b0 : outFullA_q;
   wire logic inFullA_d  = modeSet ? 1'b0 :
                           (aInSide & ~strbAHigh) ? 1'b1 :
                           rdAEnd_q ? 1'b0 : inFullA_q;
   wire logic outFullB_d = modeSet ? 1'b0 :
                           (wrBEnd_q & bOutSide) ? 1'b1 :
                           ~hsBHigh ? 1'b0 : outFullB_q;
   wire logic inFullB_d  = modeSet ? 1'b0 :
                           (bInSide & ~hsBHigh) ? 1'b1 :
                           rdBEnd_q ? 1'b0 : inFullB_q;

   // interrupt levels; the output-side line is high while the buffer is free
   wire logic irqA_d = ~modeSet & (
      (aInSide & irqTerm(inFullA_q, inSideIrqMask_q, strbAHigh, rdABusy)) |
      (aOutSide & irqTerm(~outFullA_q, outSideIrqMask_q, accAHigh, wrABusy)));
   wire logic irqB_d = ~modeSet & (
      (bInSide & irqTerm(inFullB_q, irqMaskB_q, hsBHigh, rdBBusy)) |
      (bOutSide & irqTerm(~outFullB_q, irqMaskB_q, hsBHigh, wrBBusy)));

   // port c line roles per mode
   wire logic [7:0] hsOutA =
      (aInSide | aOutSide) ? bitMask(`SPP_PC_IRQ_A) |
      (aInSide ? bitMask(`SPP_PC_INFULL_A) : 8'h00) |
      (aOutSide ? bitMask(`SPP_PC_OUTFUL_A) : 8'h00) : 8'h00;
   wire logic [7:0] hsInA =
      (aInSide ? bitMask(`SPP_PC_STRB_A) : 8'h00) |
      (aOutSide ? bitMask(`SPP_PC_ACC_A) : 8'h00);
   wire logic [7:0] hsOutB = bStrb ? (bitMask(`SPP_PC_IRQ_B) | bitMask(`SPP_PC_FULL_B)) : 8'h00;
   wire logic [7:0] hsInB  = bStrb ? bitMask(`SPP_PC_HS_B) : 8'h00;
   wire logic [7:0] hsOut  = hsOutA | hsOutB;
   wire logic [7:0] hsIn   = hsInA | hsInB;
   wire logic [7:0] hsAny  = hsOut | hsIn;
   wire logic [7:0] spareIn = {{4{dirCuIn_q}}, {4{dirClIn_q}}};

   // live handshake state, read back as driven
   wire logic [7:0] hsVal =
      ({7'h00, irqB_q} << `SPP_PC_IRQ_B) |
      ({7'h00, (dirBIn_q ? inFullB_q : ~outFullB_q)} << `SPP_PC_FULL_B) |
      ({7'h00, irqA_q} << `SPP_PC_IRQ_A) |
      ({7'h00, inFullA_q} << `SPP_PC_INFULL_A) |
      ({7'h00, ~outFullA_q} << `SPP_PC_OUTFUL_A);

   wire logic [7:0] portCOut_d  = (hsOut & hsVal) | (~hsAny & portCLatch_q);
   wire logic [7:0] portCOeN_d  = ~(hsOut | (~hsAny & ~spareIn));
   wire logic [7:0] portCRead   = (hsOut & hsVal) | (hsIn & pcSync_q) |
                                  (~hsAny & spareIn & pcSync_q) |
                                  (~hsAny & ~spareIn & portCLatch_q);

   // port c latch: lower half may be written as a group, upper only when basic
   wire logic [7:0] cWrMask     = aBasic ? 8'hff : 8'h0f;
   wire logic [7:0] portCLatch_d =
      modeSet ? `SPP_RST_DATA :
      bitOp   ? ((portCLatch_q & ~bitMask(bitSel)) | ({8{bitVal}} & bitMask(bitSel))) :
      wrC     ? ((portCLatch_q & ~cWrMask) | (wrData & cWrMask)) : portCLatch_q;

   wire logic [7:0] portARead = aInSide ? inALatch_q : (dirAIn_q ? portAIn : outALatch_q);
   wire logic [7:0] portBRead = bInSide ? inBLatch_q : (dirBIn_q ? portBIn : outBLatch_q);
   wire logic [7:0] rdData_d  = ~rdStb ? 8'h00 :
                                selA ? portARead :
                                selB ? portBRead :
                                selC ? portCRead : 8'h00;

   // port A floats in bidirectional mode unless the peripheral is accepting
   wire logic portAOeN_d = aBidir ? accAHigh : dirAIn_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         modeA_q   <= spp_pkg::SPP_A_BASIC;
         modeB_q   <= spp_pkg::SPP_B_BASIC;
         dirAIn_q  <= 1'b1;
         dirBIn_q  <= 1'b1;
         dirCuIn_q <= 1'b1;
         dirClIn_q <= 1'b1;
      end else if (modeSet) begin
         modeA_q   <= modeA_d;
         modeB_q   <= modeB_d;
         dirAIn_q  <= wrData[`SPP_CW_A_IN];
         dirBIn_q  <= wrData[`SPP_CW_B_IN];
         dirCuIn_q <= wrData[`SPP_CW_CU_IN];
         dirClIn_q <= wrData[`SPP_CW_CL_IN];
      end
   end

   // interrupt masks
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         outSideIrqMask_q <= 1'b0;
         inSideIrqMask_q  <= 1'b0;
         irqMaskB_q       <= 1'b0;
      end else if (modeSet) begin
         outSideIrqMask_q <= 1'b0;
         inSideIrqMask_q  <= 1'b0;
         irqMaskB_q       <= 1'b0;
      end else if (bitOp) begin
         if (bitSel == `SPP_PC_ACC_A && aOutSide)
            outSideIrqMask_q <= bitVal;
         if (bitSel == `SPP_PC_STRB_A && aInSide)
            inSideIrqMask_q <= bitVal;
         if (bitSel == `SPP_PC_HS_B && bStrb)
            irqMaskB_q <= bitVal;
      end
   end

   // data latches
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         outALatch_q <= `SPP_RST_DATA;
         outBLatch_q <= `SPP_RST_DATA;
         inALatch_q  <= `SPP_RST_DATA;
         inBLatch_q  <= `SPP_RST_DATA;
      end else if (modeSet) begin
         outALatch_q <= `SPP_RST_DATA;
         outBLatch_q <= `SPP_RST_DATA;
      end else begin
         if (wrA)
            outALatch_q <= wrData;
         if (wrB)
            outBLatch_q <= wrData;
         if (aInSide && !strbAHigh)
            inALatch_q <= portAIn;
         if (bInSide && !hsBHigh)
            inBLatch_q <= portBIn;
      end
   end

   // first stage feeds only the second; all four host strobe ends are registered
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pcMeta_q <= `SPP_RST_OEN;
         pcSync_q <= `SPP_RST_OEN;
         wrAEnd_q <= 1'b0;
         rdAEnd_q <= 1'b0;
         wrBEnd_q <= 1'b0;
         rdBEnd_q <= 1'b0;
      end else begin
         // lines we drive ourselves look idle, so an output turned into a strobe
         // input by a mode change cannot fake a strobe from its old level
         pcMeta_q <= portCIn | ~portCOeN_q;
         pcSync_q <= pcMeta_q;
         wrAEnd_q <= wrA;
         rdAEnd_q <= rdA;
         wrBEnd_q <= wrB;
         rdBEnd_q <= rdB;
      end
   end

   // handshake flops and port c latch
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         outFullA_q   <= 1'b0;
         inFullA_q    <= 1'b0;
         outFullB_q   <= 1'b0;
         inFullB_q    <= 1'b0;
         irqA_q       <= 1'b0;
         irqB_q       <= 1'b0;
         portCLatch_q <= `SPP_RST_DATA;
      end else begin
         outFullA_q   <= outFullA_d;
         inFullA_q    <= inFullA_d;
         outFullB_q   <= outFullB_d;
         inFullB_q    <= inFullB_d;
         irqA_q       <= irqA_d;
         irqB_q       <= irqB_d;
         portCLatch_q <= portCLatch_d;
      end
   end

   // every pin and the read data leave from a flop
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdData_q   <= `SPP_RST_DATA;
         portAOut_q <= `SPP_RST_DATA;
         portAOeN_q <= 1'b1;
         portBOut_q <= `SPP_RST_DATA;
         portBOeN_q <= 1'b1;
         portCOut_q <= `SPP_RST_DATA;
         portCOeN_q <= `SPP_RST_OEN;
      end else begin
         rdData_q   <= rdData_d;
         portAOut_q <= outALatch_q;
         portAOeN_q <= portAOeN_d;
         portBOut_q <= outBLatch_q;
         portBOeN_q <= dirBIn_q;
         portCOut_q <= portCOut_d;
         portCOeN_q <= portCOeN_d;
      end
   end

   assign rdData   = rdData_q;
   assign portAOut = portAOut_q;
   assign portAOeN = portAOeN_q;
   assign portBOut = portBOut_q;
   assign portBOeN = portBOeN_q;
   assign portCOut = portCOut_q;
   assign portCOeN = portCOeN_q;

endmodule

// *** hw/spp_pkg.sv ***
// types shared by the strobed parallel port block
// assumes: compiled before any module that names these types
package spp_pkg;

   typedef enum logic [2:0] {
      SPP_A_BASIC    = 3'b001,
      SPP_A_STROBED  = 3'b010,
      SPP_A_BIDIR    = 3'b100
   } sppModeA_t;

   typedef enum logic [1:0] {
      SPP_B_BASIC    = 2'b01,
      SPP_B_STROBED  = 2'b10
   } sppModeB_t;

endpackage

// *** sim/spp_handshake_assertions.sv ***
// checker: handshake timing of the parallel port seen at its pins
// assumes: bound to spp_handshake, one clock, async active-low reset
`timescale 1ns/1ps
module spp_handshake_assertions (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [1:0] addr,
   input wire logic [7:0] wrData,
   input wire logic       wrStb,
   input wire logic       rdStb,
   input wire logic [7:0] rdData,
   input wire logic [7:0] portAOut,
   input wire logic       portAOeN,
   input wire logic [7:0] portCIn,
   input wire logic [7:0] portCOut
);
   logic bidir_q, aOut_q, aIn_q, maskO_q;
   wire  modeWr  = wrStb && addr == 2'h3 && wrData[7];
   wire  bitWr   = wrStb && addr == 2'h3 && !wrData[7];
   wire  aWr     = wrStb && addr == 2'h0;
   wire  outLike = aOut_q || bidir_q;
   wire  inLike  = aIn_q || bidir_q;
   // shadow of group A mode and output mask, rebuilt from host writes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {bidir_q, aOut_q, aIn_q, maskO_q} <= 4'h0;
      end else if (modeWr) begin
         bidir_q <= wrData[6];
         aOut_q  <= wrData[6:5] == 2'h1 && !wrData[4];
         aIn_q   <= wrData[6:5] == 2'h1 && wrData[4];
         maskO_q <= 1'b0;
      end else if (bitWr && wrData[3:1] == 3'h6) begin
         maskO_q <= wrData[0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   rd_idle_a: assert property (!rdStb |=> rdData == 8'h00)
      else $error("read data not idle");
   mode_clr_a: assert property (modeWr |-> ##2 portAOut == 8'h00 && !portCOut[3])
      else $error("mode set did not clear");
   oe_off_a: assert property ((bidir_q && portCIn[6]) [*5] |-> portAOeN)
      else $error("port a driven without accept");
   oe_on_a: assert property ((bidir_q && !portCIn[6]) [*5] |-> !portAOeN)
      else $error("port a not driven on accept");
   full_set_a: assert property (outLike && aWr |-> ##[2:4] !portCOut[7])
      else $error("full line not low after write");
   full_clr_a: assert property (outLike && $fell(portCIn[6]) |-> ##[2:5] portCOut[7])
      else $error("full line not freed by accept");
   in_set_a: assert property (inLike && $fell(portCIn[4]) |-> ##[2:5] portCOut[5])
      else $error("input full not set by strobe");
   irq_wr_a: assert property (outLike && aWr |-> ##[1:2] !portCOut[3])
      else $error("interrupt not cleared by write");
   irq_set_a:
      assert property ((aOut_q && maskO_q && portCOut[7] && portCIn[6] && !wrStb && !rdStb)
         [*6] |-> portCOut[3]) else $error("interrupt not raised");
endmodule

bind spp_handshake spp_handshake_assertions u_spp_handshake_assertions (
   .clock(clock), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
   .rdStb(rdStb), .rdData(rdData), .portAOut(portAOut), .portAOeN(portAOeN),
   .portCIn(portCIn), .portCOut(portCOut));

// *** sim/spp_peer_model.sv ***
// peripheral model: strobes bytes into port a, accepts host output bytes
// assumes: it resolves the port a bus and port c lines from both enables
`timescale 1ns/1ps
module spp_peer_model (
   input  wire logic       clock,
   input  wire logic [7:0] portAOut,
   input  wire logic       portAOeN,
   input  wire logic [7:0] portCOut,
   input  wire logic [7:0] portCOeN,
   output logic      [7:0] portAIn,
   output logic      [7:0] portCIn,
   output logic      [7:0] gotByte
);
   logic       accH, stbH, drvA;
   logic [7:0] drvData;
   logic [7:0] lastA = 8'h00;
   logic [7:0] lastC = 8'h00;
   // undriven lines toggle every cycle so stale data never looks valid
   always @(posedge clock) begin
      lastA <= portAIn;
      lastC <= portCIn;
   end
   assign portAIn = !portAOeN ? portAOut : (drvA ? drvData : ~lastA);
   assign portCIn = (~portCOeN & portCOut)
                  | (portCOeN & {~lastC[7], accH, ~lastC[5], stbH, ~lastC[3:0]});
   // accept only once the full line has been seen low
   initial begin
      accH = 1'b1;
      stbH = 1'b1;
      drvA = 1'b0;
      forever begin
         @(posedge clock);
         if (!portCOeN[7] && portCOut[7] === 1'b0) begin
            accH <= 1'b0;
            repeat (6) @(posedge clock);
            gotByte <= portAIn;
            accH    <= 1'b1;
         end
      end
   end
   // data held a few cycles past the strobe so the resynced strobe still sees it
   task automatic push(input logic [7:0] d);
      @(posedge clock);
      drvData <= d;
      drvA    <= 1'b1;
      stbH    <= 1'b0;
      repeat (4) @(posedge clock);
      stbH <= 1'b1;
      repeat (3) @(posedge clock);
      drvA <= 1'b0;
   endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench: host register accesses against a handshaking peripheral
// assumes: design, checker and peripheral model compiled before this file
`timescale 1ns/1ps
module testbench;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wrData = 8'h00;
   logic       wrStb = 1'b0;
   logic       rdStb = 1'b0;
   logic [7:0] portBIn = 8'h00;
   logic [7:0] rdData, portAIn, portAOut, portBOut, portCIn, portCOut, portCOeN, gotByte;
   logic       portAOeN, portBOeN;
   int         err_total = 0;
   int         samples_checked = 0;
   int         cycles = 0;

   always #5 clock = ~clock;

   spp_handshake u_spp_handshake (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .portAIn(portAIn), .portAOut(portAOut), .portAOeN(portAOeN), .portBIn(portBIn),
      .portBOut(portBOut), .portBOeN(portBOeN), .portCIn(portCIn),
      .portCOut(portCOut), .portCOeN(portCOeN));
   spp_peer_model u_spp_peer_model (.clock(clock), .portAOut(portAOut),
      .portAOeN(portAOeN), .portCOut(portCOut), .portCOeN(portCOeN),
      .portAIn(portAIn), .portCIn(portCIn), .gotByte(gotByte));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // the whole run needs well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         $display("FAIL %0t: run hung", $time);
         report_and_stop();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      addr   <= a;
      wrData <= d;
      wrStb  <= 1'b1;
      @(posedge clock);
      wrStb <= 1'b0;
   endtask
   // interrupt bit is masked off in port c reads taken while it may be high; waitC checks its level on its own
   task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clock);
      addr  <= a;
      rdStb <= 1'b1;
      @(posedge clock);
      rdStb <= 1'b0;
      #1;
      chk(rdData & m, exp);
   endtask
   task automatic waitC(input int i, input logic v);
      int n;
      n = 0;
      #1;
      while (portCOut[i] !== v && n < 30) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk({7'h00, portCOut[i]}, {7'h00, v});
   endtask

   initial begin
      repeat (8) @(posedge clock);
      chk({portAOeN, portCOut[6:0]}, 8'h80);
      chk(portCOeN, 8'hff);
      rst_n <= 1'b1;
      wr(2'h3, 8'h80);
      wr(2'h2, 8'h96);
      wr(2'h1, 8'h69);
      rd(2'h2, 8'hff, 8'h96);
      chk(portCOut, 8'h96);
      chk(portBOut, 8'h69);
      chk({7'h00, portBOeN}, 8'h00);
      wr(2'h3, 8'ha0);
      // the accept line turns from output to input here: let it clear the resynchroniser
      repeat (8) @(posedge clock);
      rd(2'h2, 8'hff, 8'hc0);
      chk(portBOut, 8'h00);
      wr(2'h3, 8'h0d);
      waitC(3, 1'b1);
      rd(2'h2, 8'hf7, 8'hc0);
      wr(2'h0, 8'h5a);
      waitC(7, 1'b0);
      chk(portAOut, 8'h5a);
      waitC(7, 1'b1);
      waitC(3, 1'b1);
      wr(2'h2, 8'hff);
      rd(2'h2, 8'hf7, 8'hc7);
      wr(2'h3, 8'h0b);
      rd(2'h2, 8'hf7, 8'he7);
      wr(2'h3, 8'ha0);
      rd(2'h2, 8'hff, 8'hc0);
      wr(2'h3, 8'hc0);
      wr(2'h3, 8'h09);
      u_spp_peer_model.push(8'h3c);
      waitC(5, 1'b1);
      waitC(3, 1'b1);
      rd(2'h0, 8'hff, 8'h3c);
      waitC(3, 1'b0);
      waitC(5, 1'b0);
      wr(2'h3, 8'h0d);
      wr(2'h0, 8'ha5);
      #1;
      chk({7'h00, portAOeN}, 8'h01);
      waitC(7, 1'b0);
      waitC(7, 1'b1);
      waitC(3, 1'b1);
      chk(gotByte, 8'ha5);
      rd(2'h2, 8'hf0, 8'hd0);
      report_and_stop();
   end
endmodule
